// *** hw/noc_config_regs.sv ***
// Common configuration, interrupt mask, retry timers and buffer split of the offload engine
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
// How it works
// - Interrupt only when cause and mask both set
// - Mask bits: 7 conflict, 6 unreach, 5 PPP, 3:0 sockets
// - Retry period counts in 100 us units
// - Retry period resets to 2000, 200 ms
// - Retry high byte low address, low byte next
// - Retransmit on missing or late peer reply
// - Count retries to limit, then flag timeout
// - Receive split: two bits per socket, 8K total
// - Size codes give 1, 2, 4, 8 KB
// - Allocate from socket 0 up, skipping any socket that no longer fits
// - Receive split resets to 2 KB each
// - Transmit split works like receive split
// - Read-only auth method, resets to zero
// - LCP echo every interval times 25 ms
// - Magic register feeds LCP negotiation
// - Capture unreachable address and port, read-only
// - Four socket mode registers, 0x100 apart
// - Mode bit 7 enables UDP multicast
// - TCP bit 5 acks every data packet
// - Multicast bit 5 selects IGMP version
// - Interrupt low while any enabled cause set
// - Global causes clear by writing one
module noc_config_regs import noc_pkg::*; #(
	parameter int LCP_TICK = LCP_TICK_CYC
) (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst,
	// Register port
	input  wire logic [ADDR_W-1:0]            reg_addr,
	input  wire logic [DATA_W-1:0]            reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [DATA_W-1:0]            reg_rdata,
	// Interrupt
	output logic                              irq_n,
	// Global events from the protocol engine
	input  wire logic                         conflict_evt,
	input  wire logic                         ppp_close_evt,
	input  wire logic                         unreach_evt,
	input  wire logic [31:0]                  unreach_ip,
	input  wire logic [15:0]                  unreach_port,
	input  wire logic [NUM_SOCK-1:0]          socket_irq_flags,
	input  wire logic                         auth_evt,
	input  wire logic [15:0]                  auth_method,
	// Retransmission control per socket
	input  wire logic [NUM_SOCK-1:0]          sock_wait_start,
	input  wire logic [NUM_SOCK-1:0]          sock_reply,
	output logic      [NUM_SOCK-1:0]          sock_retransmit,
	output logic      [NUM_SOCK-1:0]          sock_timeout,
	// PPP link keepalive
	input  wire logic                         ppp_active,
	output logic                              lcp_echo_req,
	output logic      [7:0]                   lcp_magic,
	// Buffer split
	output logic      [NUM_SOCK*BUF_W-1:0]    rx_sock_size,
	output logic      [NUM_SOCK*BASE_W-1:0]   rx_sock_base,
	output logic      [NUM_SOCK*BUF_W-1:0]    tx_sock_size,
	output logic      [NUM_SOCK*BASE_W-1:0]   tx_sock_base,
	// Socket mode decode
	output logic      [NUM_SOCK*8-1:0]        sock_mode,
	output logic      [NUM_SOCK*4-1:0]        sock_proto,
	output logic      [NUM_SOCK-1:0]          sock_proto_ok,
	output logic      [NUM_SOCK-1:0]          sock_multicast,
	output logic      [NUM_SOCK-1:0]          sock_ack_every,
	output logic      [NUM_SOCK-1:0]          sock_igmp_v1
);

	// Sizes granted in socket order; a socket that no longer fits gets nothing
	function automatic logic [NUM_SOCK*BUF_W-1:0] split_sizes(input logic [7:0] split);
		logic [14:0] used;
		logic [14:0] want;
		logic [NUM_SOCK*BUF_W-1:0] res;
		used = '0;
		res  = '0;
		for (int s = 0; s < NUM_SOCK; s++) begin
			want = BUF_UNIT << split[2*s +: 2];
			if (used + want <= BUF_TOTAL) begin
				res[s*BUF_W +: BUF_W] = want[BUF_W-1:0];
				used = used + want;
			end
		end
		return res;
	endfunction

	function automatic logic [NUM_SOCK*BASE_W-1:0] split_bases(input logic [NUM_SOCK*BUF_W-1:0] sizes);
		logic [14:0] used;
		logic [NUM_SOCK*BASE_W-1:0] res;
		used = '0;
		res  = '0;
		for (int s = 0; s < NUM_SOCK; s++) begin
			res[s*BASE_W +: BASE_W] = used[BASE_W-1:0];
			used = used + {1'b0, sizes[s*BUF_W +: BUF_W]};
		end
		return res;
	endfunction

	function automatic logic [7:0] byte_of(input logic [31:0] word, input logic [1:0] idx);
		return word[(3 - idx)*8 +: 8];
	endfunction

	logic [7:0]  irq_mask_r;
	logic [7:0]  sticky_r;
	logic [15:0] retry_time_r;
	logic [7:0]  retry_lim_r;
	logic [7:0]  rx_split_r;
	logic [7:0]  tx_split_r;
	logic [15:0] auth_r;
	logic [7:0]  lcp_ivl_r;
	logic [7:0]  lcp_magic_r;
	logic [31:0] unr_ip_r;
	logic [15:0] unr_port_r;
	logic [7:0]  mode_r [NUM_SOCK];
	logic [7:0]  rdata_r;
	logic        irq_n_r;

	// Address decode
	wire         sel_cause  = (reg_addr == ADR_IRQ_CAUSE);
	wire         sel_mask   = (reg_addr == ADR_IRQ_MASK);
	wire         sel_rhi    = (reg_addr == ADR_RETRY_HI);
	wire         sel_rlo    = (reg_addr == ADR_RETRY_LO);
	wire         sel_rlim   = (reg_addr == ADR_RETRY_LIM);
	wire         sel_rxs    = (reg_addr == ADR_RX_SPLIT);
	wire         sel_txs    = (reg_addr == ADR_TX_SPLIT);
	wire         sel_ahi    = (reg_addr == ADR_AUTH_HI);
	wire         sel_alo    = (reg_addr == ADR_AUTH_LO);
	wire         sel_livl   = (reg_addr == ADR_LCP_IVL);
	wire         sel_lmag   = (reg_addr == ADR_LCP_MAGIC);
	// The address capture starts mid-word, so it is decoded by offset rather than by aligned bits
	wire [15:0]  uip_off    = reg_addr - ADR_UNR_IP0;
	wire         sel_uip    = (uip_off < 16'h0004);
	wire         sel_unreachable_port_capture  = (reg_addr[15:1] == ADR_UNR_PORT0[15:1]);
	wire [7:0]   mode_hi    = reg_addr[15:8] - ADR_SOCK_MODE0[15:8];
	wire         sel_mode   = (reg_addr[7:0] == ADR_SOCK_MODE0[7:0])
	                          && (mode_hi < 8'(NUM_SOCK * SOCK_SPACING_HI));
	wire [1:0]   mode_idx   = mode_hi[1:0];

	// Cause register: sticky bits on top, socket levels below
	wire [7:0]   cause      = {sticky_r[7:5], 1'b0, socket_irq_flags};
	wire [7:0]   set_evt    = {conflict_evt, unreach_evt, ppp_close_evt, 5'h00};
	wire [7:0]   clr_bits   = (reg_wr && sel_cause) ? (reg_wdata & STICKY_MASK) : 8'h00;
	// A new event wins over a clear in the same cycle
	wire [7:0]   sticky_nxt = (sticky_r & ~clr_bits) | set_evt;
	// Reserved mask bit 4 meets a cause bit that is always zero, so it cannot fire
	wire         irq_any    = |(cause & irq_mask_r);

	// Read mux
	logic [7:0]  rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (sel_cause)
			rd_mux = cause;
		else if (sel_mask)
			rd_mux = irq_mask_r;
		else if (sel_rhi)
			rd_mux = retry_time_r[15:8];
		else if (sel_rlo)
			rd_mux = retry_time_r[7:0];
		else if (sel_rlim)
			rd_mux = retry_lim_r;
		else if (sel_rxs)
			rd_mux = rx_split_r;
		else if (sel_txs)
			rd_mux = tx_split_r;
		else if (sel_ahi)
			rd_mux = auth_r[15:8];
		else if (sel_alo)
			rd_mux = auth_r[7:0];
		else if (sel_livl)
			rd_mux = lcp_ivl_r;
		else if (sel_lmag)
			rd_mux = lcp_magic_r;
		else if (sel_uip)
			rd_mux = byte_of(unr_ip_r, uip_off[1:0]);
		else if (sel_unreachable_port_capture)
			rd_mux = reg_addr[0] ? unr_port_r[7:0] : unr_port_r[15:8];
		else if (sel_mode)
			rd_mux = mode_r[mode_idx];
	end

	// Writable configuration
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_mask_r   <= RST_IRQ_MASK;
			retry_time_r <= RST_RETRY_TIME;
			retry_lim_r  <= RST_RETRY_LIM;
			rx_split_r   <= RST_SPLIT;
			tx_split_r   <= RST_SPLIT;
			lcp_ivl_r    <= RST_LCP_IVL;
			lcp_magic_r  <= RST_LCP_MAGIC;
		end else if (reg_wr) begin
			if (sel_mask)
				irq_mask_r <= reg_wdata;
			if (sel_rhi)
				retry_time_r[15:8] <= reg_wdata;
			if (sel_rlo)
				retry_time_r[7:0] <= reg_wdata;
			if (sel_rlim)
				retry_lim_r <= reg_wdata;
			if (sel_rxs)
				rx_split_r <= reg_wdata;
			if (sel_txs)
				tx_split_r <= reg_wdata;
			if (sel_livl)
				lcp_ivl_r <= reg_wdata;
			if (sel_lmag)
				lcp_magic_r <= reg_wdata;
		end
	end

	// Socket mode registers
	generate
		for (genvar n = 0; n < NUM_SOCK; n++) begin : g_mode
			always_ff @(posedge clk) begin
				if (rst)
					mode_r[n] <= RST_SOCK_MODE;
				else if (reg_wr && sel_mode && mode_idx == 2'(n))
					mode_r[n] <= reg_wdata;
			end
			wire [3:0] proto = mode_r[n][3:0];
			wire       multi = mode_r[n][BIT_MULTICAST];
			wire       b5    = mode_r[n][BIT_ACK_IGMP];
			assign sock_mode[n*8 +: 8]  = mode_r[n];
			assign sock_proto[n*4 +: 4] = proto;
			// Raw frame and PPP modes only exist on socket 0
			assign sock_proto_ok[n]     = (proto <= PROTO_IPRAW)
			                              || (n == 0 && (proto == PROTO_MACRAW || proto == PROTO_PPP));
			assign sock_multicast[n]    = multi && proto == PROTO_UDP;
			assign sock_ack_every[n]    = b5 && proto == PROTO_TCP;
			assign sock_igmp_v1[n]      = b5 && multi && proto == PROTO_UDP;
		end
	endgenerate

	// Status capture, cause bits, read data, interrupt
	always_ff @(posedge clk) begin
		if (rst) begin
			sticky_r   <= 8'h00;
			auth_r     <= 16'h0000;
			unr_ip_r   <= 32'h00000000;
			unr_port_r <= 16'h0000;
			rdata_r    <= 8'h00;
			irq_n_r    <= 1'b1;
		end else begin
			sticky_r <= sticky_nxt;
			if (auth_evt)
				auth_r <= auth_method;
			if (unreach_evt) begin
				unr_ip_r   <= unreach_ip;
				unr_port_r <= unreach_port;
			end
			rdata_r <= reg_rd ? rd_mux : 8'h00;
			irq_n_r <= ~irq_any;
		end
	end

	assign reg_rdata = rdata_r;
	assign irq_n     = irq_n_r;
	assign lcp_magic = lcp_magic_r;

	// Buffer split outputs, registered
	logic [NUM_SOCK*BUF_W-1:0]  rx_size_r;
	logic [NUM_SOCK*BUF_W-1:0]  tx_size_r;
	logic [NUM_SOCK*BASE_W-1:0] rx_base_r;
	logic [NUM_SOCK*BASE_W-1:0] tx_base_r;
	wire  [NUM_SOCK*BUF_W-1:0]  rx_size_nxt = split_sizes(rx_split_r);
	wire  [NUM_SOCK*BUF_W-1:0]  tx_size_nxt = split_sizes(tx_split_r);
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_size_r <= '0;
			tx_size_r <= '0;
			rx_base_r <= '0;
			tx_base_r <= '0;
		end else begin
			rx_size_r <= rx_size_nxt;
			tx_size_r <= tx_size_nxt;
			rx_base_r <= split_bases(rx_size_nxt);
			tx_base_r <= split_bases(tx_size_nxt);
		end
	end
	assign rx_sock_size = rx_size_r;
	assign tx_sock_size = tx_size_r;
	assign rx_sock_base = rx_base_r;
	assign tx_sock_base = tx_base_r;

	// 100 us tick shared by all retry timers
	logic [15:0] retry_div_r;
	wire         retry_tick = (retry_div_r == 16'(RETRY_TICK_CYC - 1));
	always_ff @(posedge clk) begin
		if (rst || retry_tick)
			retry_div_r <= 16'h0000;
		else
			retry_div_r <= retry_div_r + 16'h0001;
	end

	// A zero period still waits one tick, so the timer never spins
	wire [15:0] retry_load = (retry_time_r == 16'h0000) ? 16'h0001 : retry_time_r;

	generate
		for (genvar n = 0; n < NUM_SOCK; n++) begin : g_retry
			noc_retry_t st_r;
			logic [15:0] tmr_r;
			logic [7:0]  cnt_r;
			logic        rtx_r;
			logic        tmo_r;
			wire         expire = (st_r == RETRY_WAIT) && retry_tick && tmr_r == 16'h0001;
			always_ff @(posedge clk) begin
				if (rst) begin
					st_r  <= RETRY_IDLE;
					tmr_r <= 16'h0000;
					cnt_r <= 8'h00;
					rtx_r <= 1'b0;
					tmo_r <= 1'b0;
				end else begin
					rtx_r <= 1'b0;
					tmo_r <= 1'b0;
					unique case (st_r)
						RETRY_IDLE: begin
							if (sock_wait_start[n]) begin
								st_r  <= RETRY_WAIT;
								tmr_r <= retry_load;
								cnt_r <= 8'h00;
							end
						end
						RETRY_WAIT: begin
							if (sock_reply[n] && !expire) begin
								st_r <= RETRY_IDLE;
							end else if (expire) begin
								if (cnt_r == retry_lim_r) begin
									tmo_r <= 1'b1;
									st_r  <= RETRY_IDLE;
								end else begin
									rtx_r <= 1'b1;
									cnt_r <= cnt_r + 8'h01;
									tmr_r <= retry_load;
								end
							end else if (retry_tick) begin
								tmr_r <= tmr_r - 16'h0001;
							end
						end
					endcase
				end
			end
			assign sock_retransmit[n] = rtx_r;
			assign sock_timeout[n]    = tmo_r;
		end
	endgenerate

	// LCP echo interval: 25 ms prescaler, then interval count
	logic [31:0] lcp_div_r;
	logic [7:0]  lcp_cnt_r;
	logic        lcp_req_r;
	wire         lcp_tick = (lcp_div_r == 32'(LCP_TICK - 1));
	always_ff @(posedge clk) begin
		if (rst || !ppp_active) begin
			lcp_div_r <= 32'h00000000;
			lcp_cnt_r <= 8'h00;
			lcp_req_r <= 1'b0;
		end else begin
			lcp_req_r <= 1'b0;
			if (lcp_tick) begin
				lcp_div_r <= 32'h00000000;
				if (lcp_cnt_r + 8'h01 >= lcp_ivl_r) begin
					lcp_cnt_r <= 8'h00;
					lcp_req_r <= 1'b1;
				end else begin
					lcp_cnt_r <= lcp_cnt_r + 8'h01;
				end
			end else begin
				lcp_div_r <= lcp_div_r + 32'h00000001;
			end
		end
	end
	assign lcp_echo_req = lcp_req_r;

endmodule // noc_config_regs

// *** hw/noc_pkg.sv ***
// Shared constants and types for the offload common configuration registers
package noc_pkg;
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 8;
	localparam int          NUM_SOCK        = 4;
	localparam int          BUF_W           = 14;
	localparam int          BASE_W          = 13;
	// Register byte addresses
	localparam logic [15:0] ADR_IRQ_CAUSE   = 16'h0015;
	localparam logic [15:0] ADR_IRQ_MASK    = 16'h0016;
	localparam logic [15:0] ADR_RETRY_HI    = 16'h0017;
	localparam logic [15:0] ADR_RETRY_LO    = 16'h0018;
	localparam logic [15:0] ADR_RETRY_LIM   = 16'h0019;
	localparam logic [15:0] ADR_RX_SPLIT    = 16'h001A;
	localparam logic [15:0] ADR_TX_SPLIT    = 16'h001B;
	localparam logic [15:0] ADR_AUTH_HI     = 16'h001C;
	localparam logic [15:0] ADR_AUTH_LO     = 16'h001D;
	localparam logic [15:0] ADR_LCP_IVL     = 16'h0028;
	localparam logic [15:0] ADR_LCP_MAGIC   = 16'h0029;
	localparam logic [15:0] ADR_UNR_IP0     = 16'h002A;
	localparam logic [15:0] ADR_UNR_PORT0   = 16'h002E;
	localparam logic [15:0] ADR_SOCK_MODE0  = 16'h0400;
	localparam logic [7:0]  SOCK_SPACING_HI = 8'h01;
	// Reset values
	localparam logic [7:0]  RST_IRQ_MASK    = 8'h00;
	localparam logic [15:0] RST_RETRY_TIME  = 16'h07D0;
	localparam logic [7:0]  RST_RETRY_LIM   = 8'h08;
	localparam logic [7:0]  RST_SPLIT       = 8'h55;
	localparam logic [7:0]  RST_LCP_IVL     = 8'h28;
	localparam logic [7:0]  RST_LCP_MAGIC   = 8'h00;
	localparam logic [7:0]  RST_SOCK_MODE   = 8'h00;
	// Cause and mask bit positions
	localparam int          BIT_CONFLICT    = 7;
	localparam int          BIT_UNREACH     = 6;
	localparam int          BIT_PPP_CLOSE   = 5;
	localparam logic [7:0]  STICKY_MASK     = 8'hE0;
	// Socket mode fields
	localparam int          BIT_MULTICAST   = 7;
	localparam int          BIT_ACK_IGMP    = 5;
	localparam logic [3:0]  PROTO_CLOSED    = 4'h0;
	localparam logic [3:0]  PROTO_TCP       = 4'h1;
	localparam logic [3:0]  PROTO_UDP       = 4'h2;
	localparam logic [3:0]  PROTO_IPRAW     = 4'h3;
	localparam logic [3:0]  PROTO_MACRAW    = 4'h4;
	localparam logic [3:0]  PROTO_PPP       = 4'h5;
	// Buffer memory
	localparam logic [14:0] BUF_TOTAL       = 15'h2000;
	localparam logic [14:0] BUF_UNIT        = 15'h0400;
	// Timing
	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          RETRY_UNIT_US   = 100;
	localparam int          LCP_UNIT_MS     = 25;
	localparam int          RETRY_TICK_CYC  = (RETRY_UNIT_US * 1000) / CLK_PERIOD_NS;
	localparam int          LCP_TICK_CYC    = (LCP_UNIT_MS * 1000000) / CLK_PERIOD_NS;
	typedef enum logic {RETRY_IDLE, RETRY_WAIT} noc_retry_t;
endpackage

// *** verification/noc_config_regs_properties.sv ***
// Port-level checks of the common configuration registers
`timescale 1ns/1ns
module noc_config_regs_properties import noc_pkg::*; (
	// Clock and reset
	input wire logic                  clk,
	input wire logic                  rst,
	// Register port
	input wire logic [ADDR_W-1:0]     reg_addr,
	input wire logic [DATA_W-1:0]     reg_wdata,
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire logic [DATA_W-1:0]     reg_rdata,
	// Interrupt and events
	input wire logic                  irq_n,
	input wire logic                  conflict_evt,
	input wire logic                  unreach_evt,
	input wire logic [NUM_SOCK-1:0]   socket_irq_flags,
	// Timers and modes
	input wire logic [NUM_SOCK-1:0]   sock_retransmit,
	input wire logic [NUM_SOCK-1:0]   sock_timeout,
	input wire logic                  ppp_active,
	input wire logic                  lcp_echo_req,
	input wire logic [NUM_SOCK*8-1:0] sock_mode,
	input wire logic [NUM_SOCK*4-1:0] sock_proto,
	input wire logic [NUM_SOCK-1:0]   sock_multicast
);
	logic [7:0] mask_r;
	logic       mask_wr;
	// Shadow of the mask so the irq checks need no internal probes
	assign mask_wr = reg_wr && reg_addr == ADR_IRQ_MASK;
	always_ff @(posedge clk) begin
		if (rst)
			mask_r <= RST_IRQ_MASK;
		else if (mask_wr)
			mask_r <= reg_wdata;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_conflict;
		conflict_evt && mask_r[BIT_CONFLICT] && !mask_wr;
	endsequence
	sequence s_unreach;
		unreach_evt && mask_r[BIT_UNREACH] && !mask_wr;
	endsequence
	sequence s_ppp_off;
		!ppp_active ##1 !ppp_active;
	endsequence
	a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read answer");
	a_conflict_irq: assert property (s_conflict |-> ##2 !irq_n)
		else $error("enabled conflict event gave no interrupt");
	a_unreach_irq: assert property (s_unreach |-> ##2 !irq_n)
		else $error("enabled unreachable event gave no interrupt");
	a_socket_irq: assert property (|(socket_irq_flags & mask_r[3:0]) |=> !irq_n)
		else $error("enabled socket flag gave no interrupt");
	a_masked_quiet: assert property (mask_r == 8'h00 |=> irq_n)
		else $error("interrupt with every cause masked");
	a_retx_tmo_apart: assert property (!(|(sock_retransmit & sock_timeout)))
		else $error("retransmit and timeout together");
	a_retx_single: assert property (sock_retransmit[1] |=> !sock_retransmit[1] [*8])
		else $error("retransmit pulses too close");
	a_lcp_idle: assert property (s_ppp_off |-> !lcp_echo_req)
		else $error("echo request with link inactive");
	a_lcp_spacing: assert property (lcp_echo_req |=> !lcp_echo_req [*8])
		else $error("echo requests too close");
	a_mc_udp_only: assert property (sock_multicast[0] == (sock_mode[BIT_MULTICAST] && sock_proto[3:0] == PROTO_UDP))
		else $error("multicast flag not tied to udp and bit 7");
endmodule // noc_config_regs_properties

bind noc_config_regs noc_config_regs_properties noc_config_regs_properties_i (.*);

// *** verification/noc_config_regs_tb.sv ***
// Self-checking bench for the common configuration registers
`timescale 1ns/1ns
module noc_config_regs_tb import noc_pkg::*;;
	logic clk = 1'b0, rst = 1'b1, aevt = 1'b0, ppp = 1'b0;
	logic [2:0] evt = 3'h0;
	logic [3:0] sflg = 4'h0, wst = 4'h0, rep = 4'h0;
	logic [31:0] uip = '0, seed = 32'h421FF56C, sip;
	logic [15:0] unreachable_port_capture = '0, ameth = '0, sport, a;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, magic, d;
	logic wr, rd, irq_n, lcp;
	logic [3:0] retx, tmo, pok, mc, acke, igv1;
	logic [55:0] rxs, txs;
	logic [51:0] rxb, txb;
	logic [31:0] mode;
	logic [15:0] proto;
	int num_errors = 0, comparisons = 0, cyc = 0, nbad = 0, ntmo = 0, ttmo = 0, n;
	int mdl[int];
	int tr[$], lq[$];
	int ra[17] = '{16'h0016, 16'h0017, 16'h0018, 16'h0019, 16'h001A, 16'h001B, 16'h001C, 16'h001D, 16'h0028,
		16'h0029, 16'h002A, 16'h002E, 16'h0400, 16'h0500, 16'h0600, 16'h0700, 16'h0030};
	int rv[17] = '{8'h00, 8'h07, 8'hD0, 8'h08, 8'h55, 8'h55, 8'h00, 8'h00, 8'h28, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00};
	logic [15:0] am[2] = '{16'hC023, 16'hC223};
	always #50 clk = ~clk;
	noc_host_model host_i (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata));
	noc_config_regs #(.LCP_TICK(10)) noc_config_regs_i (.clk(clk), .rst(rst), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq_n(irq_n), .conflict_evt(evt[2]),
		.unreach_evt(evt[1]), .ppp_close_evt(evt[0]), .unreach_ip(uip), .unreach_port(unreachable_port_capture),
		.socket_irq_flags(sflg), .auth_evt(aevt), .auth_method(ameth), .sock_wait_start(wst), .sock_reply(rep),
		.sock_retransmit(retx), .sock_timeout(tmo), .ppp_active(ppp), .lcp_echo_req(lcp), .lcp_magic(magic),
		.rx_sock_size(rxs), .rx_sock_base(rxb), .tx_sock_size(txs), .tx_sock_base(txb), .sock_mode(mode),
		.sock_proto(proto), .sock_proto_ok(pok), .sock_multicast(mc), .sock_ack_every(acke), .sock_igmp_v1(igv1));
	always @(posedge clk) begin
		cyc++;
		if (retx[1])
			tr.push_back(cyc);
		if (tmo[1])
			ttmo = cyc;
		ntmo += tmo[1];
		nbad += retx[2] | tmo[2];
		if (lcp)
			lq.push_back(cyc);
	end
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("mismatches %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Read-only and unmapped places keep their model value
	task automatic put(input logic [15:0] ad, input logic [7:0] dt);
		host_i.wr(ad, dt);
		if ((ad >= 16'h0016 && ad <= 16'h001B) || ad == 16'h0028 || ad == 16'h0029 || (ad[7:0] == 8'h00 && ad[15:10] == 6'h01))
			mdl[ad] = (ad == ADR_IRQ_MASK) ? dt & 8'hEF : dt;
	endtask
	task automatic get(input logic [15:0] ad, input logic [31:0] exp);
		logic [7:0] v;
		host_i.rd(ad, v);
		chk(v, exp);
	endtask
	task automatic pulse(input logic [2:0] e);
		@(posedge clk);
		evt <= e;
		uip <= rnd();
		unreachable_port_capture <= seed[15:0];
		@(posedge clk);
		evt <= 3'h0;
		repeat (2) @(negedge clk);
	endtask
	task automatic split_chk(input int c, input logic [55:0] sz, input logic [51:0] bs);
		int rem;
		int sn;
		rem = 8192;
		for (int s = 0; s < 4; s++) begin
			sn = 1024 << ((c >> (2 * s)) & 3);
			if (sn > rem) begin
				chk(sz[s*14+:14], 0);
			end else begin
				chk(sz[s*14+:14], sn);
				chk(bs[s*13+:13], 8192 - rem);
				rem -= sn;
			end
		end
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		test_done();
	end
	initial begin
		for (int i = 0; i < 17; i++)
			mdl[ra[i]] = rv[i];
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 17; i++)
			get(ra[i], mdl[ra[i]]);
		repeat (40) put(ra[rnd() % 17], rnd());
		for (int i = 0; i < 17; i++)
			get(ra[i], mdl[ra[i]]);
		chk(magic, mdl[16'h0029]);
		for (int c = 0; c < 256; c++) begin
			put(ADR_RX_SPLIT, c);
			put(ADR_TX_SPLIT, ~c);
			repeat (2) @(negedge clk);
			split_chk(c, rxs, rxb);
			split_chk(255 - c, txs, txb);
		end
		put(ADR_IRQ_MASK, 8'hF1);
		for (int k = 0; k < 3; k++) begin
			pulse(3'b100 >> k);
			chk(irq_n, 1'b0);
			if (k == 1) begin
				sip = uip;
				sport = unreachable_port_capture;
			end
			get(ADR_IRQ_CAUSE, 8'h80 >> k);
			put(ADR_IRQ_CAUSE, 8'h80 >> k);
			repeat (2) @(negedge clk);
			chk(irq_n, 1'b1);
		end
		for (int b = 0; b < 4; b++)
			get(ADR_UNR_IP0 + b, sip[31-8*b-:8]);
		get(ADR_UNR_PORT0, sport[15:8]);
		get(ADR_UNR_PORT0 + 1, sport[7:0]);
		put(ADR_IRQ_MASK, 8'h01);
		pulse(3'b100);
		chk(irq_n, 1'b1);
		@(posedge clk);
		sflg <= 4'b0010;
		repeat (2) @(negedge clk);
		chk(irq_n, 1'b1);
		@(posedge clk);
		sflg <= 4'b0001;
		repeat (2) @(negedge clk);
		chk(irq_n, 1'b0);
		get(ADR_IRQ_CAUSE, 8'h81);
		put(ADR_IRQ_CAUSE, 8'h8F);
		repeat (2) @(negedge clk);
		chk(irq_n, 1'b0);
		get(ADR_IRQ_CAUSE, 8'h01);
		@(posedge clk);
		sflg <= 4'b0000;
		repeat (2) @(negedge clk);
		chk(irq_n, 1'b1);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			aevt <= 1'b1;
			ameth <= am[i];
			@(posedge clk);
			aevt <= 1'b0;
			get(ADR_AUTH_HI, am[i][15:8]);
			get(ADR_AUTH_LO, am[i][7:0]);
		end
		put(ADR_RETRY_HI, 8'h00);
		put(ADR_RETRY_LO, 8'h02);
		put(ADR_RETRY_LIM, 8'h02);
		@(posedge clk);
		wst <= 4'b0110;
		@(posedge clk);
		wst <= 4'b0000;
		repeat (5) @(posedge clk);
		rep <= 4'b0100;
		@(posedge clk);
		rep <= 4'b0000;
		repeat (7000) @(posedge clk);
		chk(tr.size(), 2);
		chk(ntmo, 1);
		chk(tr[1] - tr[0], 2000);
		chk(ttmo - tr[1], 2000);
		chk(nbad, 0);
		put(ADR_LCP_IVL, 8'h03);
		@(posedge clk);
		ppp <= 1'b1;
		repeat (120) @(posedge clk);
		ppp <= 1'b0;
		repeat (2) @(posedge clk);
		chk(lq.size() >= 3, 1);
		chk(lq[2] - lq[1], 30);
		n = lq.size();
		repeat (60) @(posedge clk);
		chk(lq.size(), n);
		for (int s = 0; s < 4; s++) begin
			for (int p = 0; p < 6; p++) begin
				d = (rnd() & 8'hA0) | p;
				a = ADR_SOCK_MODE0 + (s << 8);
				put(a, d);
				@(negedge clk);
				chk(mode[s*8+:8], d);
				chk(proto[s*4+:4], p);
				chk(pok[s], s == 0 || p < 4);
				chk(mc[s], d[7] && p == 2);
				chk(acke[s], d[5] && p == 1);
				chk(igv1[s], d[5] && d[7] && p == 2);
			end
		end
		test_done();
	end
endmodule // noc_config_regs_tb

// *** verification/noc_host_model.sv ***
// Host processor model driving the register port
`timescale 1ns/1ns
module noc_host_model import noc_pkg::*; (
	// Clock
	input  wire logic              clk,
	// Register port
	output logic      [ADDR_W-1:0] reg_addr,
	output logic      [DATA_W-1:0] reg_wdata,
	output logic                   reg_wr,
	output logic                   reg_rd,
	input  wire logic [DATA_W-1:0] reg_rdata
);
	initial begin
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Released lines show the inverse so stale values never look valid
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= (a == ADR_IRQ_MASK) ? d & 8'hEF : d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge clk);
		d = reg_rdata;
	endtask
endmodule // noc_host_model
